//--- hdl/partition_feature_id_regs.sv
// Partitioning feature identification registers, read-only apart from the selector.
// Assumes accesses arrive one per cycle on the request struct, with
// the secure bit telling which feature frame is addressed.
`timescale 1ns/10ps
`include "partition_feature_id_defs.svh"

module partition_feature_id_regs
    import partition_feature_id_pkg::*;
#(
    parameter arch_rev_t ARCH_REV = REV_V1P0,
    parameter bit CAP_PRESENT = 1'b1,
    parameter bit PORTION_PRESENT = 1'b1,
    parameter bit SEL_PRESENT = 1'b0,
    parameter logic [3:0] MAX_INSTANCE = 4'h0,
    parameter bit SPLIT_FRAMES = 1'b0,
    parameter logic [15:0] INST_PRESENT = 16'hffff,
    parameter logic [95:0] CAP_WD_S = {16{6'h08}},
    parameter logic [95:0] CAP_WD_NS = {16{6'h08}},
    parameter logic [255:0] BM_WD_S = {16{16'h0010}},
    parameter logic [255:0] BM_WD_NS = {16{16'h0010}}
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_req_t req_i,
    output reg_rsp_t rsp_o,
    output logic force_nonsecure_avail_o,
    output logic config_error_o,
    output logic [3:0] sel_s_o,
    output logic [3:0] sel_ns_o,
    output logic [10:0] bitmap_words_s_o,
    output logic [10:0] bitmap_words_ns_o
);

    // ------------------------------------------------------------
    // Revision decode
    // ------------------------------------------------------------

    // Legal pairs only; anything else is flagged as a bad build.
    localparam bit REV_LEGAL = (ARCH_REV == REV_NONE) ||
        (ARCH_REV == REV_V0P1) || (ARCH_REV == REV_V1P0) ||
        (ARCH_REV == REV_V1P1); // [R3]

    // Both fields of the pair, each in its own nibble.
    localparam logic [3:0] MAJOR = ARCH_REV[`MAJOR_MSB:`MAJOR_LSB];
    localparam logic [3:0] MINOR = ARCH_REV[`MINOR_MSB:`MINOR_LSB];

    // The zero pair means no partitioning at all.
    localparam bit ANY_FEATURE = REV_LEGAL && (ARCH_REV != REV_NONE);

    // Feature flags are only honoured when partitioning exists.
    localparam bit CAP_ON = CAP_PRESENT && ANY_FEATURE;
    localparam bit POR_ON = PORTION_PRESENT && ANY_FEATURE;
    localparam bit SEL_ON = SEL_PRESENT && ANY_FEATURE;

    // Without a selector only instance zero exists.
    localparam logic [3:0] SEL_LIMIT = SEL_ON ? MAX_INSTANCE : 4'h0;

    // ------------------------------------------------------------
    // Per-instance tables
    // ------------------------------------------------------------

    logic [5:0] cap_s [16];
    logic [5:0] cap_ns [16];
    logic [15:0] bm_s [16];
    logic [15:0] bm_ns [16];
    logic [15:0] inst_bad;

    // Each instance gets its frame copies and a range check.
    // Removed instances report zero in every per-instance field.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_inst
            logic live;
            logic [5:0] cs;
            logic [5:0] cn;
            logic [15:0] bs;
            logic [15:0] bn;
            assign live = INST_PRESENT[gi] &&
                (4'(gi) <= SEL_LIMIT);
            assign cs = CAP_WD_S[gi*6 +: 6];
            // Without split frames the secure table serves both.
            assign cn = SPLIT_FRAMES ?
                CAP_WD_NS[gi*6 +: 6] : cs; // [R11]
            assign bs = BM_WD_S[gi*16 +: 16];
            assign bn = SPLIT_FRAMES ?
                BM_WD_NS[gi*16 +: 16] : bs; // [R11]
            assign cap_s[gi] = live ? cs : 6'h00;
            assign cap_ns[gi] = live ? cn : 6'h00;
            assign bm_s[gi] = live ? bs : 16'h0000;
            assign bm_ns[gi] = live ? bn : 16'h0000;
            // Widths must lie inside their documented ranges.
            assign inst_bad[gi] = live && (
                (CAP_ON && (cs < `CAP_WD_MIN ||
                    cs > `CAP_WD_MAX)) || // [R9]
                (CAP_ON && (cn < `CAP_WD_MIN ||
                    cn > `CAP_WD_MAX)) ||
                (POR_ON && (bs < `BITMAP_WD_MIN ||
                    bs > `BITMAP_WD_MAX)) || // [R14]
                (POR_ON && (bn < `BITMAP_WD_MIN ||
                    bn > `BITMAP_WD_MAX)));
        end
    endgenerate

    // ------------------------------------------------------------
    // Instance selector copies
    // ------------------------------------------------------------

    logic [3:0] sel_s_q;
    logic [3:0] sel_ns_q;
    logic [3:0] wr_sel;
    logic sel_wr;
    logic sel_ok;

    // A selector write names a value in the selector field.
    assign wr_sel = req_i.wdata[`SEL_MSB:`SEL_LSB];
    assign sel_wr = req_i.valid && req_i.write &&
        (req_i.addr == `OFF_PARTITION_SELECT);

    // Values past the largest instance are dropped.
    assign sel_ok = SEL_ON && (wr_sel <= SEL_LIMIT); // [R16]

    // Secure frame selector, picked by writes from that frame.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_s_q <= `SEL_RESET;
        end else if (sel_wr && req_i.secure && sel_ok) begin
            sel_s_q <= wr_sel; // [R16]
        end
    end

    // Non-secure frame selector, kept apart from the secure one.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_ns_q <= `SEL_RESET;
        end else if (sel_wr && !req_i.secure && sel_ok) begin
            sel_ns_q <= wr_sel; // [R16]
        end
    end

    assign sel_s_o = sel_s_q;
    assign sel_ns_o = sel_ns_q;

    // ------------------------------------------------------------
    // Register images for the addressed frame
    // ------------------------------------------------------------

    logic [3:0] sel_cur;
    logic [31:0] aid_word;
    logic [31:0] cap_word;
    logic [31:0] bm_word;
    logic [31:0] sel_word;

    // The frame of the access picks which selector applies.
    assign sel_cur = req_i.secure ? sel_s_q : sel_ns_q; // [R7]

    // Same revision image whatever frame is used.
    assign aid_word = {24'h000000, MAJOR, MINOR}; // [R1] [R2] [R6]

    // Capacity width of the selected instance, zero when absent.
    always_comb begin
        cap_word = 32'h00000000;
        if (CAP_ON) begin // [R8]
            if (req_i.secure) begin
                cap_word[`CAP_WD_MSB:0] = cap_s[sel_cur]; // [R10] [R12]
            end else begin
                cap_word[`CAP_WD_MSB:0] = cap_ns[sel_cur]; // [R10]
            end
        end
    end

    // Bitmap width of the selected instance, zero when absent.
    always_comb begin
        bm_word = 32'h00000000;
        if (POR_ON) begin // [R13]
            if (req_i.secure) begin
                bm_word[`BITMAP_WD_MSB:0] = bm_s[sel_cur]; // [R12]
            end else begin
                bm_word[`BITMAP_WD_MSB:0] = bm_ns[sel_cur];
            end
        end
    end

    // Selector read-back; the rest of that register lives elsewhere.
    always_comb begin
        sel_word = 32'h00000000;
        if (SEL_ON) begin
            sel_word[`SEL_MSB:`SEL_LSB] = sel_cur;
        end
    end

    // ------------------------------------------------------------
    // Access answer
    // ------------------------------------------------------------

    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic ack_q;

    // Address decode; unmapped offsets and all writes return zero.
    always_comb begin
        rd_d = 32'h00000000;
        if (req_i.write) begin
            rd_d = 32'h00000000; // [R5] [R17]
        end else if (req_i.addr == `OFF_ARCH_VERSION_ID) begin
            rd_d = aid_word;
        end else if (req_i.addr == `OFF_CAPACITY_FRACTION_WIDTH_ID) begin
            rd_d = cap_word;
        end else if (req_i.addr == `OFF_PORTION_BITMAP_WIDTH_ID) begin
            rd_d = bm_word;
        end else if (req_i.addr == `OFF_PARTITION_SELECT) begin
            rd_d = sel_word;
        end
    end

    // Every access, read or write, is answered the next cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_i.valid; // [R17]
        end
    end

    // Read data is held until the next access is taken.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_q <= 32'h00000000;
        end else if (req_i.valid) begin
            rd_q <= rd_d;
        end
    end

    assign rsp_o.ack = ack_q;
    assign rsp_o.rdata = rd_q;

    // ------------------------------------------------------------
    // Side outputs for the partitioning logic
    // ------------------------------------------------------------

    logic [15:0] bm_cur_s;
    logic [15:0] bm_cur_ns;
    logic [10:0] words_s_d;
    logic [10:0] words_ns_d;
    logic [10:0] words_s_q;
    logic [10:0] words_ns_q;
    logic cfg_err_q;

    assign bm_cur_s = POR_ON ? bm_s[sel_s_q] : 16'h0000;
    assign bm_cur_ns = POR_ON ? bm_ns[sel_ns_q] : 16'h0000;

    // Count of 32-bit bitmap words, rounded up, not capped at 1024.
    function automatic logic [10:0] words_of(input logic [15:0] wd);
        logic [16:0] sum;
        sum = {1'b0, wd} + 17'h0001f;
        return 11'(sum >> `BITMAP_WORD_SHIFT); // [R15]
    endfunction

    assign words_s_d = words_of(bm_cur_s);
    assign words_ns_d = words_of(bm_cur_ns);

    // Word counts follow the selectors one cycle later.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            words_s_q <= 11'h000;
            words_ns_q <= 11'h000;
        end else begin
            words_s_q <= words_s_d; // [R15]
            words_ns_q <= words_ns_d;
        end
    end

    assign bitmap_words_s_o = words_s_q;
    assign bitmap_words_ns_o = words_ns_q;

    // A bad build shows from the first edge after reset.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_err_q <= 1'b0;
        end else begin
            cfg_err_q <= !REV_LEGAL || (|inst_bad); // [R3] [R9] [R14]
        end
    end

    assign config_error_o = cfg_err_q;

    // Forcing accesses non-secure exists only in the v0.1 revision.
    assign force_nonsecure_avail_o = (ARCH_REV == REV_V0P1); // [R4]

endmodule

//--- hdl/partition_feature_id_defs.svh
// Constants of the partition feature identification bank.
// Assumes a 32-bit word map with byte offsets inside one feature frame.
// Operation
// [R1] Major in 7:4, minor in 3:0, rest zero
// [R2] Low byte reads 0x01, 0x10 or 0x11; a REV_NONE build reads 0x00
// [R3] Only four legal revision pairs exist
// [R4] Force non-secure offered only by v0.1
// [R5] Identification registers are read-only in both frames
// [R6] Revision register identical through both frames
// [R7] Separate secure and non-secure frames exist
// [R8] Capacity register reads zero when absent
// [R9] Capacity fraction width 1..16, upper zero
// [R10] Secure copy describes secure capacity control
// [R11] Per-frame copies where values differ
// [R12] Per-instance fields follow the selected instance
// [R13] Portion register reads zero when absent
// [R14] Bitmap width 1..32768, upper bits zero
// [R15] Wide bitmap spans up to 1024 words
// [R16] Selector picks instance up to maximum
// [R17] Writes to identification registers are ignored
`ifndef PARTITION_FEATURE_ID_DEFS_SVH
`define PARTITION_FEATURE_ID_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_ARCH_VERSION_ID 12'h020
`define OFF_PORTION_BITMAP_WIDTH_ID 12'h030
`define OFF_CAPACITY_FRACTION_WIDTH_ID 12'h038
`define OFF_PARTITION_SELECT 12'h100

// ----------------------------------------------------------------
// Field positions, limits and reset values
// ----------------------------------------------------------------
`define MAJOR_MSB 7
`define MAJOR_LSB 4
`define MINOR_MSB 3
`define MINOR_LSB 0
`define CAP_WD_MSB 5
`define BITMAP_WD_MSB 15
`define SEL_MSB 27
`define SEL_LSB 24
`define CAP_WD_MIN 6'h01
`define CAP_WD_MAX 6'h10
`define BITMAP_WD_MIN 16'h0001
`define BITMAP_WD_MAX 16'h8000
`define BITMAP_WORD_SHIFT 5
`define BITMAP_MAX_WORDS 11'h400
`define SEL_RESET 4'h0

`endif

//--- hdl/partition_feature_id_pkg.sv
// Types shared by the partition feature identification bank.
// Assumes the constants header is included by the design file.
package partition_feature_id_pkg;

    // One register access: frame select, byte offset and data.
    typedef struct packed {
        logic valid;
        logic write;
        logic secure;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // The answer to an access, one cycle after it is taken.
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } reg_rsp_t;

    // The four legal architecture revision codes.
    typedef enum logic [7:0] {
        REV_NONE = 8'h00,
        REV_V0P1 = 8'h01,
        REV_V1P0 = 8'h10,
        REV_V1P1 = 8'h11
    } arch_rev_t;

endpackage

//--- bench/partition_feature_id_regs_monitor.sv
// Concurrent checks on the ports of the identification register bank.
// Assumes one clock domain and the shared package compiled first.
`timescale 1ns/10ps
module partition_feature_id_regs_monitor
    import partition_feature_id_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_req_t req_i,
    input wire reg_rsp_t rsp_o,
    input wire logic force_nonsecure_avail_o,
    input wire logic config_error_o,
    input wire logic [3:0] sel_s_o,
    input wire logic [3:0] sel_ns_o,
    input wire logic [10:0] bitmap_words_s_o,
    input wire logic [10:0] bitmap_words_ns_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // --------------------------------
    // Helper terms
    // --------------------------------
    // Read requests, split by register offset.
    logic rd;
    logic rd_arch;
    assign rd = req_i.valid && !req_i.write;
    assign rd_arch = rd && req_i.addr == 12'h020;

    // --------------------------------
    // Assertions
    // --------------------------------
    chk_ack_follows: assert property (req_i.valid |=> rsp_o.ack)
        else $error("access not answered one cycle later");
    chk_ack_quiet: assert property (!req_i.valid |=> !rsp_o.ack)
        else $error("answer without an access");
    chk_write_zero: assert property (req_i.valid && req_i.write
        |=> rsp_o.rdata == 32'h0) else $error("write returned data");
    chk_arch_legal: assert property (rd_arch
        |=> rsp_o.rdata inside {32'h0, 32'h1, 32'h10, 32'h11})
        else $error("bad revision code");
    chk_arch_twins: assert property (rd_arch ##1 rd_arch
        |=> rsp_o.rdata == $past(rsp_o.rdata))
        else $error("revision differs between reads");
    chk_force_match: assert property (rd_arch
        |=> force_nonsecure_avail_o == (rsp_o.rdata[7:0] == 8'h01))
        else $error("force flag disagrees with revision");
    chk_cap_width: assert property (rd && req_i.addr == 12'h038
        |=> rsp_o.rdata[31:6] == 26'h0 && rsp_o.rdata[5:0] <= 6'h10)
        else $error("capacity width out of range");
    chk_bitmap_upper: assert property (rd && req_i.addr == 12'h030
        |=> rsp_o.rdata[31:16] == 16'h0) else $error("bitmap upper set");
    chk_sel_hold: assert property (!(req_i.valid && req_i.write)
        |=> $stable(sel_s_o) && $stable(sel_ns_o))
        else $error("selector moved without a write");
    chk_words_limit: assert property (bitmap_words_s_o <= 11'h400
        && bitmap_words_ns_o <= 11'h400) else $error("too many words");

    // Main scenarios reached.
    cover property (req_i.valid && req_i.write && req_i.addr == 12'h100);
    cover property (rd && req_i.addr == 12'h030);
    cover property (rd_arch ##1 rd_arch);
endmodule

bind partition_feature_id_regs partition_feature_id_regs_monitor
    u_partition_feature_id_regs_monitor(.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .rsp_o(rsp_o), .force_nonsecure_avail_o(force_nonsecure_avail_o),
    .config_error_o(config_error_o), .sel_s_o(sel_s_o),
    .sel_ns_o(sel_ns_o), .bitmap_words_s_o(bitmap_words_s_o),
    .bitmap_words_ns_o(bitmap_words_ns_o));

//--- bench/partition_feature_id_regs_bench.sv
// Self-checking bench for the identification register bank.
// Assumes the package, header and design are compiled first.
`timescale 1ns/10ps
module partition_feature_id_regs_bench
    import partition_feature_id_pkg::*;
;
    localparam logic [95:0] CWS = {{12{6'h08}}, 6'h10, 6'h01, 6'h05, 6'h0c};
    localparam logic [95:0] CWN = {16{6'h03}};
    localparam logic [255:0] BWS = {{12{16'h0010}}, 16'h8000, 16'h0021,
        16'h0020, 16'h0001};
    localparam logic [255:0] BWN = {16{16'h0040}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    reg_req_t req_i = '0;
    reg_rsp_t rsp_o;
    logic force_nonsecure_avail_o, config_error_o;
    logic [3:0] sel_s_o, sel_ns_o;
    logic [10:0] bitmap_words_s_o, bitmap_words_ns_o;
    int err_total = 0;
    int total_checks = 0;
    int ms = 0;
    int mn = 0;
    logic [31:0] lf = 32'hf8b2;
    logic [11:0] tab [6] = '{12'h020, 12'h030, 12'h038, 12'h100, 12'h024,
        12'hffc};

    // Design with four selectable instances and split frames.
    partition_feature_id_regs #(.ARCH_REV(REV_V1P1), .SEL_PRESENT(1'b1),
        .MAX_INSTANCE(4'h3), .SPLIT_FRAMES(1'b1), .CAP_WD_S(CWS),
        .CAP_WD_NS(CWN), .BM_WD_S(BWS), .BM_WD_NS(BWN))
    u_partition_feature_id_regs(.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
        .rsp_o(rsp_o), .force_nonsecure_avail_o(force_nonsecure_avail_o),
        .config_error_o(config_error_o), .sel_s_o(sel_s_o),
        .sel_ns_o(sel_ns_o), .bitmap_words_s_o(bitmap_words_s_o),
        .bitmap_words_ns_o(bitmap_words_ns_o));

    // ----------------------------------------
    // Model and helpers
    // ----------------------------------------
    // Clock of 25 ns period.
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Next value of the stimulus shift register.
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Expected read data for a frame, using the model selectors.
    function automatic logic [31:0] exp_rd(input bit s, input logic [11:0] a);
        int i;
        i = s ? ms : mn;
        case (a)
            12'h020: return 32'h11;
            12'h038: return s ? 32'(CWS[i*6+:6]) : 32'(CWN[i*6+:6]);
            12'h030: return s ? 32'(BWS[i*16+:16]) : 32'(BWN[i*16+:16]);
            12'h100: return 32'(i) << 24;
            default: return 32'h0;
        endcase
    endfunction

    // One access, then its answer and the selectors one cycle later.
    task automatic acc(input bit w, input bit s, input logic [11:0] a,
            input logic [31:0] d);
        logic [31:0] e;
        req_i = '{valid: 1'b1, write: w, secure: s, addr: a, wdata: d};
        e = w ? 32'h0 : exp_rd(s, a);
        if (w && a == 12'h100 && d[27:24] <= 4'h3) begin
            if (s) ms = d[27:24]; else mn = d[27:24];
        end
        @(negedge clk_i);
        chk({31'h0, rsp_o.ack}, 32'h1);
        chk(rsp_o.rdata, e);
        chk({28'h0, sel_s_o}, 32'(ms));
        chk({28'h0, sel_ns_o}, 32'(mn));
    endtask

    // Idle cycle, checking quiet answer and bitmap word counts.
    task automatic idle;
        req_i.valid = 1'b0;
        @(negedge clk_i);
        chk({31'h0, rsp_o.ack}, 32'h0);
        chk(32'(bitmap_words_s_o), (32'(BWS[ms*16+:16]) + 31) / 32);
        chk(32'(bitmap_words_ns_o), (32'(BWN[mn*16+:16]) + 31) / 32);
        chk({30'h0, force_nonsecure_avail_o, config_error_o}, 32'h0);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        for (int f = 0; f < 2; f++) begin
            acc(1'b0, f[0], 12'h020, 32'h0);
            acc(1'b0, !f[0], 12'h020, 32'h0);
            acc(1'b0, f[0], 12'h028, 32'h0);
            for (int n = 0; n < 5; n++) begin
                acc(1'b1, f[0], 12'h100, 32'(n) << 24);
                acc(1'b0, f[0], 12'h038, 32'h0);
                acc(1'b0, f[0], 12'h030, 32'h0);
                acc(1'b0, !f[0], 12'h030, 32'h0);
                acc(1'b0, f[0], 12'h100, 32'h0);
                idle();
            end
            acc(1'b1, f[0], 12'h020, 32'hffffffff);
            acc(1'b1, f[0], 12'h038, 32'hffffffff);
            acc(1'b0, f[0], 12'h038, 32'h0);
        end
        for (int k = 0; k < 300; k++) begin
            lf = nxt(lf);
            acc(lf[7], lf[8], tab[lf[4:2] % 6], nxt(lf));
            if (lf[11:9] == 3'h0) idle();
        end
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        ms = 0;
        mn = 0;
        idle();
        acc(1'b0, 1'b1, 12'h038, 32'h0);
        idle();
        stop_test();
    end

    // Watchdog far beyond the expected run length.
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
endmodule
